// ==== logic/cal_pkg.sv ====
package cal_pkg;

  // serial frame layout
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FRAME_LEN = 5'h10;
  localparam int WR_BIT = 15;
  localparam int ADDR_HI = 13;
  localparam int ADDR_LO = 8;
  localparam int ADDR_W = 6;

  // register byte addresses (even = lower byte, odd = upper byte)
  localparam logic [5:0] ADDR_X_ACCEL_OUT = 6'h04;
  localparam logic [5:0] ADDR_Y_ACCEL_OUT = 6'h06;
  localparam logic [5:0] ADDR_X_TILT_OUT = 6'h0C;
  localparam logic [5:0] ADDR_Y_TILT_OUT = 6'h0E;
  localparam logic [5:0] ADDR_X_ACCEL_OFFSET = 6'h10;
  localparam logic [5:0] ADDR_Y_ACCEL_OFFSET = 6'h12;
  localparam logic [5:0] ADDR_X_ACCEL_GAIN = 6'h14;
  localparam logic [5:0] ADDR_Y_ACCEL_GAIN = 6'h16;
  localparam logic [5:0] ADDR_X_TILT_OFFSET = 6'h18;
  localparam logic [5:0] ADDR_Y_TILT_OFFSET = 6'h1A;
  localparam logic [5:0] ADDR_X_TILT_GAIN = 6'h1C;
  localparam logic [5:0] ADDR_Y_TILT_GAIN = 6'h1E;
  localparam logic [5:0] ADDR_AVERAGING_COUNT = 6'h38;
  localparam logic [5:0] ADDR_COMMAND = 6'h3E;

  // calibration block occupies 0x10..0x1F, index = addr[3:1]
  localparam logic [1:0] CAL_PAGE = 2'h1;
  localparam int NUM_CAL = 8;
  localparam logic [2:0] IDX_X_ACCEL_OFFSET = 3'h0;
  localparam logic [2:0] IDX_Y_ACCEL_OFFSET = 3'h1;
  localparam logic [2:0] IDX_X_ACCEL_GAIN = 3'h2;
  localparam logic [2:0] IDX_Y_ACCEL_GAIN = 3'h3;
  localparam logic [2:0] IDX_X_TILT_OFFSET = 3'h4;
  localparam logic [2:0] IDX_Y_TILT_OFFSET = 3'h5;
  localparam logic [2:0] IDX_X_TILT_GAIN = 3'h6;
  localparam logic [2:0] IDX_Y_TILT_GAIN = 3'h7;

  // field masks and reset values
  localparam logic [15:0] MASK_ACCEL_OFFSET = 16'h0FFF;
  localparam logic [15:0] MASK_TILT_OFFSET = 16'h01FF;
  localparam logic [15:0] MASK_GAIN = 16'h0FFF;
  localparam logic [15:0] RST_OFFSET = 16'h0000;
  localparam logic [15:0] RST_GAIN = 16'h0800;
  localparam logic [7:0] RST_AVERAGING_COUNT = 8'h00;
  localparam int NULL_BIT = 0;

  // arithmetic
  localparam int RAW_W = 14;
  localparam int GAIN_SHIFT = 11;
  localparam int OUT_MAX = 8191;
  localparam int OUT_MIN = -8192;
  localparam int ACCEL_OFF_MAX = 2047;
  localparam int ACCEL_OFF_MIN = -2048;
  localparam int TILT_OFF_MAX = 255;
  localparam int TILT_OFF_MIN = -256;

  typedef struct packed {
    logic [RAW_W-1:0] x_accel;
    logic [RAW_W-1:0] y_accel;
    logic [RAW_W-1:0] x_tilt;
    logic [RAW_W-1:0] y_tilt;
  } axis_set_t;

  typedef enum logic [1:0] {
    SPI_IDLE = 2'h0,
    SPI_RECV = 2'h1,
    SPI_EXEC = 2'h3
  } spi_state_t;

endpackage

// ==== logic/tilt_accel_calibration.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - each control register is 16 bits, split into upper and lower byte addresses
// - upper byte holds bits 15..8, lower byte bits 7..0
// - calibration values are 12 bits, tilt offsets 9 bits, LSB aligned
// - offsets are two's complement, gains are unsigned binary
// - output equals gain times (raw plus offset)
// - each axis uses only its own offset and gain pair
// - null command loads each offset with the negated axis reading
// - after null, the four outputs read near zero while each reading lies within its offset span
// - all eight calibration registers are writable individually over the serial port
// - accel offsets use bits 11:0, reset 0x0000, span -2048..+2047
// - gains use bits 11:0, reset 0x0800 meaning unity, 0..4095 is gain 0..2
// - tilt offsets use bits 8:0, reset 0x0000, span -256..+255
// - calibration registers are readable and writable and meant to be nonvolatile; here ARST_N reloads their reset values
// - write frame: bit 15 set, address in 13:8, one data byte; one byte changes
// - read returns the upper byte then the lower byte of the same register
module tilt_accel_calibration (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic DIN,
  output logic DOUT,
  input wire cal_pkg::axis_set_t SAMPLE,
  input wire logic SAMPLE_VALID,
  output cal_pkg::axis_set_t CAL_OUT,
  output logic CAL_VALID
);
  import cal_pkg::*;

  function automatic logic [15:0] cal_mask(input logic [2:0] idx);
    unique case (idx)
      IDX_X_ACCEL_OFFSET, IDX_Y_ACCEL_OFFSET: cal_mask = MASK_ACCEL_OFFSET;
      IDX_X_TILT_OFFSET, IDX_Y_TILT_OFFSET: cal_mask = MASK_TILT_OFFSET;
      default: cal_mask = MASK_GAIN;
    endcase
  endfunction

  function automatic logic [15:0] cal_reset(input logic [2:0] idx);
    unique case (idx)
      IDX_X_ACCEL_GAIN, IDX_Y_ACCEL_GAIN, IDX_X_TILT_GAIN, IDX_Y_TILT_GAIN:
        cal_reset = RST_GAIN;
      default: cal_reset = RST_OFFSET;
    endcase
  endfunction

  // sign-extend an offset field to 16 bits
  function automatic logic signed [15:0] off_ext(input logic [15:0] off, input logic tilt);
    if (tilt) begin
      off_ext = $signed({{7{off[8]}}, off[8:0]});
    end else begin
      off_ext = $signed({{4{off[11]}}, off[11:0]});
    end
  endfunction

  // gain * (raw + offset), gain 0x800 is unity, result saturated to the output width
  function automatic logic [RAW_W-1:0] calib(input logic [RAW_W-1:0] raw,
                                             input logic [15:0] off,
                                             input logic [15:0] gain,
                                             input logic tilt);
    logic signed [15:0] sum;
    logic signed [28:0] prod;
    logic signed [28:0] shf;
    sum = $signed({{2{raw[RAW_W-1]}}, raw}) + off_ext(off, tilt);
    prod = sum * $signed({1'b0, gain[11:0]});
    shf = prod >>> GAIN_SHIFT;
    if (shf > OUT_MAX) begin
      calib = 14'h1FFF;
    end else if (shf < OUT_MIN) begin
      calib = 14'h2000;
    end else begin
      calib = shf[RAW_W-1:0];
    end
  endfunction

  // negated reading, clamped into the offset span and masked to the field
  function automatic logic [15:0] null_off(input logic [RAW_W-1:0] raw, input logic tilt);
    logic signed [15:0] neg;
    logic signed [15:0] lim_hi;
    logic signed [15:0] lim_lo;
    neg = -$signed({{2{raw[RAW_W-1]}}, raw});
    lim_hi = tilt ? 16'(TILT_OFF_MAX) : 16'(ACCEL_OFF_MAX);
    lim_lo = tilt ? 16'(TILT_OFF_MIN) : 16'(ACCEL_OFF_MIN);
    if (neg > lim_hi) begin
      neg = lim_hi;
    end else if (neg < lim_lo) begin
      neg = lim_lo;
    end
    null_off = neg & (tilt ? MASK_TILT_OFFSET : MASK_ACCEL_OFFSET);
  endfunction

  // pin synchronisers
  logic sclk_m_r, sclk_s_r, sclk_d_r;
  logic cs_m_r, cs_s_r;
  logic din_m_r, din_s_r;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sclk_m_r <= 1'b1;
      sclk_s_r <= 1'b1;
      sclk_d_r <= 1'b1;
      cs_m_r <= 1'b1;
      cs_s_r <= 1'b1;
      din_m_r <= 1'b0;
      din_s_r <= 1'b0;
    end else begin
      sclk_m_r <= SCLK;
      sclk_s_r <= sclk_m_r;
      sclk_d_r <= sclk_s_r;
      cs_m_r <= CS_N;
      cs_s_r <= cs_m_r;
      din_m_r <= DIN;
      din_s_r <= din_m_r;
    end
  end

  logic sclk_rise, sclk_fall;
  assign sclk_rise = sclk_s_r & ~sclk_d_r;
  assign sclk_fall = ~sclk_s_r & sclk_d_r;

  // serial frame engine
  spi_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [15:0] rx_r, rx_nxt;
  logic [15:0] tx_r, tx_nxt;
  logic dout_r, dout_nxt;
  logic [15:0] rd_word;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    unique case (state_r)
      SPI_IDLE: begin
        if (!cs_s_r) begin
          state_nxt = SPI_RECV;
          cnt_nxt = '0;
        end
      end
      SPI_RECV: begin
        if (cs_s_r) begin
          state_nxt = (cnt_r == FRAME_LEN) ? SPI_EXEC : SPI_IDLE;
        end else begin
          if (sclk_rise && cnt_r != FRAME_LEN) begin
            rx_nxt = {rx_r[FRAME_BITS-2:0], din_s_r};
            cnt_nxt = cnt_r + 5'h01;
          end
          if (sclk_fall && cnt_r != '0) begin
            tx_nxt = {tx_r[FRAME_BITS-2:0], 1'b0};
          end
        end
      end
      SPI_EXEC: begin
        state_nxt = SPI_IDLE;
        tx_nxt = rx_r[WR_BIT] ? 16'h0000 : rd_word;
      end
      default: state_nxt = SPI_IDLE;
    endcase
    dout_nxt = tx_nxt[FRAME_BITS-1];
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_r <= SPI_IDLE;
      cnt_r <= '0;
      rx_r <= 16'h0000;
      tx_r <= 16'h0000;
      dout_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      dout_r <= dout_nxt;
    end
  end

  // decoded frame
  logic exec, wr_cmd, cal_hit, null_cmd;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata;
  logic [2:0] cal_idx;
  assign exec = (state_r == SPI_EXEC);
  assign wr_cmd = exec & rx_r[WR_BIT];
  assign addr = rx_r[ADDR_HI:ADDR_LO];
  assign wdata = rx_r[7:0];
  assign cal_idx = addr[3:1];
  assign cal_hit = (addr[5:4] == CAL_PAGE);
  assign null_cmd = wr_cmd & (addr == ADDR_COMMAND) & wdata[NULL_BIT];

  // register file and calibrated outputs
  logic [15:0] cal_r [NUM_CAL];
  logic [15:0] cal_nxt [NUM_CAL];
  logic [7:0] avg_r, avg_nxt;
  axis_set_t raw_r, raw_nxt;
  axis_set_t out_r, out_nxt;
  logic valid_r, valid_nxt;

  always_comb begin
    for (int i = 0; i < NUM_CAL; i++) begin
      cal_nxt[i] = cal_r[i];
    end
    avg_nxt = avg_r;
    raw_nxt = raw_r;
    out_nxt = out_r;
    valid_nxt = SAMPLE_VALID;
    if (wr_cmd && cal_hit) begin
      if (addr[0]) begin
        cal_nxt[cal_idx] = {wdata, cal_r[cal_idx][7:0]} & cal_mask(cal_idx);
      end else begin
        cal_nxt[cal_idx] = {cal_r[cal_idx][15:8], wdata} & cal_mask(cal_idx);
      end
    end
    if (wr_cmd && addr == ADDR_AVERAGING_COUNT) begin
      avg_nxt = wdata;
    end
    if (null_cmd) begin
      cal_nxt[IDX_X_ACCEL_OFFSET] = null_off(raw_r.x_accel, 1'b0);
      cal_nxt[IDX_Y_ACCEL_OFFSET] = null_off(raw_r.y_accel, 1'b0);
      cal_nxt[IDX_X_TILT_OFFSET] = null_off(raw_r.x_tilt, 1'b1);
      cal_nxt[IDX_Y_TILT_OFFSET] = null_off(raw_r.y_tilt, 1'b1);
    end
    if (SAMPLE_VALID) begin
      raw_nxt = SAMPLE;
      out_nxt.x_accel = calib(SAMPLE.x_accel, cal_r[IDX_X_ACCEL_OFFSET],
                              cal_r[IDX_X_ACCEL_GAIN], 1'b0);
      out_nxt.y_accel = calib(SAMPLE.y_accel, cal_r[IDX_Y_ACCEL_OFFSET],
                              cal_r[IDX_Y_ACCEL_GAIN], 1'b0);
      out_nxt.x_tilt = calib(SAMPLE.x_tilt, cal_r[IDX_X_TILT_OFFSET],
                             cal_r[IDX_X_TILT_GAIN], 1'b1);
      out_nxt.y_tilt = calib(SAMPLE.y_tilt, cal_r[IDX_Y_TILT_OFFSET],
                             cal_r[IDX_Y_TILT_GAIN], 1'b1);
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < NUM_CAL; i++) begin
        cal_r[i] <= cal_reset(3'(i));
      end
      avg_r <= RST_AVERAGING_COUNT;
      raw_r <= '0;
      out_r <= '0;
      valid_r <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_CAL; i++) begin
        cal_r[i] <= cal_nxt[i];
      end
      avg_r <= avg_nxt;
      raw_r <= raw_nxt;
      out_r <= out_nxt;
      valid_r <= valid_nxt;
    end
  end

  // read data: either byte address of a register returns the whole word
  always_comb begin
    rd_word = 16'h0000;
    if (cal_hit) begin
      rd_word = cal_r[cal_idx] & cal_mask(cal_idx);
    end else begin
      unique case ({addr[5:1], 1'b0})
        ADDR_X_ACCEL_OUT: rd_word = 16'($signed(out_r.x_accel));
        ADDR_Y_ACCEL_OUT: rd_word = 16'($signed(out_r.y_accel));
        ADDR_X_TILT_OUT: rd_word = 16'($signed(out_r.x_tilt));
        ADDR_Y_TILT_OUT: rd_word = 16'($signed(out_r.y_tilt));
        ADDR_AVERAGING_COUNT: rd_word = {8'h00, avg_r};
        default: rd_word = 16'h0000;
      endcase
    end
  end

  assign DOUT = dout_r;
  assign CAL_OUT = out_r;
  assign CAL_VALID = valid_r;

endmodule // tilt_accel_calibration

// ==== test/cal_chk.sv ====
`timescale 1ns/1ps
module cal_chk (
  input logic CLK,
  input logic ARST_N,
  input logic SCLK,
  input logic CS_N,
  input logic DIN,
  input logic DOUT,
  input cal_pkg::axis_set_t SAMPLE,
  input logic SAMPLE_VALID,
  input cal_pkg::axis_set_t CAL_OUT,
  input logic CAL_VALID
);
  import cal_pkg::*;
  logic touched_r;
  logic touched_nxt;
  logic [4:0] act_r;
  logic [4:0] act_nxt;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // touched: a frame has begun since reset; act: recent sclk low or cs high
  always_comb begin
    touched_nxt = touched_r | !CS_N;
    act_nxt = {act_r[3:0], !SCLK || CS_N};
  end
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      touched_r <= 1'b0;
      act_r <= 5'h1F;
    end else begin
      touched_r <= touched_nxt;
      act_r <= act_nxt;
    end
  end
  sequence s_taken;
    SAMPLE_VALID;
  endsequence
  sequence s_answer;
    ##1 CAL_VALID;
  endsequence
  a_valid_follows: assert property (s_taken |-> s_answer)
    else $error("sample not answered by cal_valid");
  a_valid_cause: assert property (CAL_VALID |-> $past(SAMPLE_VALID))
    else $error("cal_valid without a sample");
  a_out_held: assert property (!CAL_VALID |-> $stable(CAL_OUT))
    else $error("cal_out moved without cal_valid");
  a_reset_outputs: assert property ($rose(ARST_N) |-> !DOUT && !CAL_VALID && CAL_OUT == '0)
    else $error("outputs not cleared by reset");
  a_reset_identity: assert property (CAL_VALID && !touched_r |-> CAL_OUT == $past(SAMPLE))
    else $error("default calibration is not identity");
  a_dout_idle: assert property (!touched_r |-> !DOUT)
    else $error("dout active before any frame");
  a_dout_on_fall: assert property ($changed(DOUT) |-> |act_r)
    else $error("dout changed while sclk high");
  a_dout_stands: assert property ((!CS_N && SCLK) [*3] |-> $stable(DOUT))
    else $error("dout unstable during sclk high");
endmodule // cal_chk
bind tilt_accel_calibration cal_chk u_chk (.CLK, .ARST_N, .SCLK, .CS_N, .DIN, .DOUT, .SAMPLE,
  .SAMPLE_VALID, .CAL_OUT, .CAL_VALID);

// ==== test/spi_host.sv ====
`timescale 1ns/1ps
module spi_host (
  input logic clk,
  output logic sclk,
  output logic cs_n,
  output logic din,
  input logic dout
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b1;
  end
  // mode 3 frame, msb first; sclk half period of 4 clk, 6 clk gap after
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    @(negedge clk);
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b0;
      din = tx[i];
      repeat (4) @(negedge clk);
      rx[i] = dout;
      sclk = 1'b1;
      repeat (4) @(negedge clk);
    end
    cs_n = 1'b1;
    din = ~din;
    repeat (6) @(negedge clk);
  endtask
endmodule // spi_host

// ==== test/tb_tilt_accel_calibration.sv ====
`timescale 1ns/1ps
module tb_tilt_accel_calibration;
  import cal_pkg::*;
  logic clk;
  logic arst_n;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout;
  logic sample_valid;
  logic cal_valid;
  axis_set_t sample;
  axis_set_t cal_out;
  logic [15:0] rx;
  logic [15:0] p;
  logic [5:0] a;
  int failures;
  int cmp_count;
  int off_v[4] = '{-2048, 2047, -256, 255};
  int gain_v[4] = '{4095, 4095, 0, 1024};
  int raw_v[4] = '{1000, 8000, 500, -700};
  int nul_v[4] = '{-1500, 2000, -200, 100};
  logic [2:0] oidx[4] = '{IDX_X_ACCEL_OFFSET, IDX_Y_ACCEL_OFFSET, IDX_X_TILT_OFFSET,
    IDX_Y_TILT_OFFSET};
  tilt_accel_calibration u_dut (.CLK(clk), .ARST_N(arst_n), .SCLK(sclk), .CS_N(cs_n),
    .DIN(din), .DOUT(dout), .SAMPLE(sample), .SAMPLE_VALID(sample_valid),
    .CAL_OUT(cal_out), .CAL_VALID(cal_valid));
  spi_host u_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] ad, input logic [7:0] d);
    u_host.xfer({2'b10, ad, d}, rx);
  endtask
  task automatic rd(input logic [5:0] ad, input logic [15:0] exp);
    u_host.xfer({2'b00, ad, 8'h00}, rx);
    u_host.xfer(16'h0000, rx);
    check(rx, exp);
  endtask
  function automatic logic [15:0] mask_of(input int i);
    return i[1] ? MASK_GAIN : (i[2] ? MASK_TILT_OFFSET : MASK_ACCEL_OFFSET);
  endfunction
  function automatic logic [13:0] model(input int raw, input int off, input int g);
    int v;
    v = ((raw + off) * g) >>> GAIN_SHIFT;
    if (v > OUT_MAX) v = OUT_MAX;
    if (v < OUT_MIN) v = OUT_MIN;
    return v[13:0];
  endfunction
  // one sample through the calibration path, compared axis by axis
  task automatic push(input int r[4], input logic [13:0] e[4]);
    @(negedge clk);
    for (int k = 0; k < 4; k++) sample[55-14*k -: 14] = r[k][13:0];
    sample_valid = 1'b1;
    @(negedge clk);
    sample_valid = 1'b0;
    check({15'h0, cal_valid}, 16'h0001);
    for (int k = 0; k < 4; k++) check({2'b00, cal_out[55-14*k -: 14]}, {2'b00, e[k]});
    @(negedge clk);
    check({15'h0, cal_valid}, 16'h0000);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    logic [13:0] e[4];
    failures = 0;
    cmp_count = 0;
    arst_n = 1'b0;
    sample = '0;
    sample_valid = 1'b0;
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    for (int k = 0; k < 4; k++) e[k] = raw_v[k][13:0];
    e[1] = 14'h1F40;
    raw_v[1] = 8000;
    push(raw_v, e);
    for (int i = 0; i < 8; i++) rd(6'h10 + 6'(2 * i), i[1] ? RST_GAIN : RST_OFFSET);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      a = 6'h10 + 6'(2 * i);
      wr(a | 6'h01, 8'hFF);
      wr(a, 8'hFF);
      rd(a | 6'h01, mask_of(i));
    end
    wr(ADDR_X_ACCEL_GAIN, 8'hAA);
    rd(ADDR_X_ACCEL_GAIN | 6'h01, 16'h0FAA);
    wr(ADDR_AVERAGING_COUNT, 8'h08);
    rd(ADDR_AVERAGING_COUNT, 16'h0008);
    $display("test register access done");
    for (int k = 0; k < 4; k++) begin
      a = 6'h10 + 6'(2 * oidx[k]);
      p = 16'(off_v[k]) & mask_of(oidx[k]);
      wr(a | 6'h01, p[15:8]);
      wr(a, p[7:0]);
      p = 16'(gain_v[k]);
      wr(a + 6'h05, p[15:8]);
      wr(a + 6'h04, p[7:0]);
      e[k] = model(raw_v[k], off_v[k], gain_v[k]);
    end
    push(raw_v, e);
    rd(ADDR_X_ACCEL_OUT, {{2{e[0][13]}}, e[0]});
    rd(ADDR_Y_TILT_OUT | 6'h01, {{2{e[3][13]}}, e[3]});
    $display("test calibration math done");
    for (int k = 0; k < 4; k++) e[k] = model(nul_v[k], off_v[k], gain_v[k]);
    push(nul_v, e);
    wr(ADDR_COMMAND, 8'h01);
    for (int k = 0; k < 4; k++) begin
      rd(6'h10 + 6'(2 * oidx[k]), 16'(-nul_v[k]) & mask_of(oidx[k]));
      e[k] = 14'h0000;
    end
    // a command without the null bit must leave the loaded offsets in place
    wr(ADDR_COMMAND, 8'h00);
    rd(ADDR_X_ACCEL_OFFSET, 16'(-nul_v[0]) & MASK_ACCEL_OFFSET);
    push(nul_v, e);
    $display("test null command done");
    tally_and_finish();
  end
endmodule // tb_tilt_accel_calibration
